// ---- rtl/puq_pkg.sv ----
// power-up event qualifier: constants, register map, state type
// assumes a 25 MHz ref_clk and a 32-bit apb master
// Behaviour
// - overvoltage debounce is picked by a two-bit code: 00 10us, 01 100us, 10 1000us, 11 reserved.
// - with the power-on pin high, the first slot starts within 1.5 ms of the supply crossing undervoltage.
// - the 1.5 ms budget is for level mode only; after a valid event level and edge modes time alike.
// - crossing undervoltage clears the low-power-off bit, and with the pin low the block stays in low-power off.
// - with the bit at 0, a pin rise leads through the bias phase to the first slot within 800 us.
// - fuse loading completes and is flagged within 600 us of the supply crossing undervoltage; the code flags it 3 ref_clk cycles after 600 us.
// - software may change the low-power-off bit only in run, and it holds until the next undervoltage crossing.
// - with pin sense 0, the pin driven high in an off state is a power-up event.
// - with pin sense 1, the pin falling and staying low for the debounce time is a power-up event.
// - an event counts only above undervoltage and below overvoltage, unless lockout is off or its shutdown select is 0.
// - trim, fuse and self-test faults must all be 0 and no thermal shutdown for an event to count.
package puq_pkg;
    localparam int CLK_MHZ          = 25;
    localparam int OV_DBNC0_US      = 10;
    localparam int OV_DBNC1_US      = 100;
    localparam int OV_DBNC2_US      = 1000;
    localparam int OV_DBNC0_CYC     = OV_DBNC0_US * CLK_MHZ;
    localparam int OV_DBNC1_CYC     = OV_DBNC1_US * CLK_MHZ;
    localparam int OV_DBNC2_CYC     = OV_DBNC2_US * CLK_MHZ;
    localparam int FUSE_LOAD_MAX_US = 600;
    localparam int FUSE_LOAD_CYC    = FUSE_LOAD_MAX_US * CLK_MHZ;
    localparam int PWRUP_LPM_MAX_US = 800;
    localparam int PWRUP_LPM_CYC    = PWRUP_LPM_MAX_US * CLK_MHZ;
    localparam int STARTUP_MAX_US   = 1500;
    localparam int STARTUP_CYC      = STARTUP_MAX_US * CLK_MHZ;
    localparam int BIAS_US          = 100;
    localparam int BIAS_CYC         = BIAS_US * CLK_MHZ;

    localparam logic [1:0] OVSEL_10US   = 2'h0;
    localparam logic [1:0] OVSEL_100US  = 2'h1;
    localparam logic [1:0] OVSEL_1000US = 2'h2;

    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_DBNC   = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;

    localparam int CTRL_LPOFF_BIT = 0;
    localparam int CTRL_OVSEL_LSB = 1;
    localparam int CTRL_OVEN_BIT  = 3;
    localparam logic        CTRL_LPOFF_RST = 1'h0;
    localparam logic [1:0]  CTRL_OVSEL_RST = 2'h0;
    localparam logic        CTRL_OVEN_RST  = 1'h1;
    localparam logic [15:0] DBNC_RST       = 16'h0100;

    localparam int ST_STATE_LSB = 0;
    localparam int ST_FDONE_BIT = 3;
    localparam int ST_FPIN_BIT  = 4;
    localparam int ST_FOVS_BIT  = 5;
    localparam int ST_QUAL_BIT  = 6;
    localparam int ST_OVF_BIT   = 7;
    localparam int ST_PEND_BIT  = 8;

    // synchroniser lanes
    localparam int SY_PIN  = 0;
    localparam int SY_UV   = 1;
    localparam int SY_OV   = 2;
    localparam int SY_TRIM = 3;
    localparam int SY_FUSE = 4;
    localparam int SY_STST = 5;
    localparam int SY_TSD  = 6;
    localparam int SY_FPIN = 7;
    localparam int SY_FOVS = 8;
    localparam int SY_N    = 9;

    typedef enum logic [2:0] {
        S_NOPWR,
        S_FUSE,
        S_LPOFF,
        S_BIAS,
        S_RUN
    } puq_state_t;
endpackage : puq_pkg

// ---- rtl/puq_ov_if.sv ----
// carrier between the qualifier and its overvoltage filter
// assumes the raw flag is already synchronised to ref_clk
`timescale 1ns/100ps
interface puq_ov_if;
    logic       ov_raw;
    logic [1:0] sel;
    logic       ov_flag;
    modport filt (input ov_raw, input sel, output ov_flag);
    modport user (output ov_raw, output sel, input ov_flag);
endinterface : puq_ov_if

// ---- rtl/puq_ov_filter.sv ----
// debounce of the input overvoltage comparator
// assumes ov_raw is synchronous to ref_clk
`timescale 1ns/100ps
module puq_ov_filter #(
    parameter int CW    = 15,
    parameter int C_10  = puq_pkg::OV_DBNC0_CYC,
    parameter int C_100 = puq_pkg::OV_DBNC1_CYC,
    parameter int C_1K  = puq_pkg::OV_DBNC2_CYC
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    puq_ov_if.filt    ov
);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic [CW-1:0] lim;
    logic          flag_r;
    logic          flag_nxt;

    always_comb begin
        case (ov.sel)
            puq_pkg::OVSEL_10US:   lim = CW'(C_10);
            puq_pkg::OVSEL_100US:  lim = CW'(C_100);
            puq_pkg::OVSEL_1000US: lim = CW'(C_1K);
            // reserved code: longest filter is the safe side
            default:               lim = CW'(C_1K);
        endcase
        cnt_nxt  = '0;
        flag_nxt = flag_r;
        if (ov.ov_raw != flag_r) begin
            if (cnt_r + CW'(1) >= lim) begin
                flag_nxt = ov.ov_raw;
            end else begin
                cnt_nxt = cnt_r + CW'(1);
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_r  <= '0;
            flag_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            flag_r <= flag_nxt;
        end
    end

    assign ov.ov_flag = flag_r;
endmodule : puq_ov_filter

// ---- rtl/puq_qualifier.sv ----
// power-up event qualifier top: pin sensing, qualification, startup fsm
// assumes analog comparators and fault lines arrive asynchronously
`timescale 1ns/100ps
module puq_qualifier #(
    parameter int FUSE_CYC = puq_pkg::FUSE_LOAD_CYC,
    parameter int BIAS_CYC = puq_pkg::BIAS_CYC,
    parameter int OV_1K    = puq_pkg::OV_DBNC2_CYC,
    parameter int CW       = 16
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        power_on_pin,
    input  wire logic        vin_above_uv,
    input  wire logic        vin_above_ovlo,
    input  wire logic        trim_fault,
    input  wire logic        fuse_fault,
    input  wire logic        self_test_fault,
    input  wire logic        thermal_shutdown,
    input  wire logic        fused_pin_sense_select,
    input  wire logic        fused_overvoltage_shutdown_select,
    output logic             fuse_load_done,
    output logic             low_power_off_state,
    output logic             run_mode,
    output logic             first_slot_start
);
    logic [puq_pkg::SY_N-1:0] raw;
    logic [puq_pkg::SY_N-1:0] s1_r;
    logic [puq_pkg::SY_N-1:0] s2_r;

    assign raw = {fused_overvoltage_shutdown_select, fused_pin_sense_select,
                  thermal_shutdown, self_test_fault, fuse_fault, trim_fault,
                  vin_above_ovlo, vin_above_uv, power_on_pin};

    genvar gi;
    generate
        for (gi = 0; gi < puq_pkg::SY_N; gi++) begin : g_sync
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    s1_r[gi] <= 1'b0;
                    s2_r[gi] <= 1'b0;
                end else begin
                    s1_r[gi] <= raw[gi];
                    s2_r[gi] <= s1_r[gi];
                end
            end
        end
    endgenerate

    logic pin;
    logic uv_ok;
    assign pin   = s2_r[puq_pkg::SY_PIN];
    assign uv_ok = s2_r[puq_pkg::SY_UV];

    puq_ov_if ovc ();
    puq_ov_filter #(
        .CW    (15),
        .C_10  (puq_pkg::OV_DBNC0_CYC),
        .C_100 (puq_pkg::OV_DBNC1_CYC),
        .C_1K  (OV_1K)
    ) u_ovf (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ov      (ovc.filt)
    );

    puq_pkg::puq_state_t st_r, st_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [15:0]   dcnt_r, dcnt_nxt;
    logic          armed_r, armed_nxt;
    logic          pend_r, pend_nxt;
    logic          pin_d_r, uv_d_r;
    logic          fpin_r, fpin_nxt;
    logic          fovs_r, fovs_nxt;
    logic          fdone_r, fdone_nxt;
    logic          slot_r, slot_nxt;
    logic          lpoff_r, lpoff_nxt;
    logic [1:0]    ovsel_r, ovsel_nxt;
    logic          oven_r, oven_nxt;
    logic [15:0]   dbnc_r, dbnc_nxt;
    logic [31:0]   prdata_r, prdata_nxt;
    logic          pready_r, pready_nxt;
    logic          pslverr_r, pslverr_nxt;
    logic          uv_rise, pin_fall, evt, qual, wr_fire, access;
    logic [31:0]   rd_val;
    logic          rd_hit;

    assign ovc.ov_raw = s2_r[puq_pkg::SY_OV];
    assign ovc.sel    = ovsel_r;

    assign uv_rise  = uv_ok & ~uv_d_r;
    assign pin_fall = ~pin & pin_d_r;
    assign qual = uv_ok
                & (~ovc.ov_flag | ~oven_r | ~fovs_r)
                & ~s2_r[puq_pkg::SY_TRIM] & ~s2_r[puq_pkg::SY_FUSE]
                & ~s2_r[puq_pkg::SY_STST] & ~s2_r[puq_pkg::SY_TSD];
    // level mode: pin high; edge mode: debounced low after a fall
    assign evt = fpin_r ? pend_r : pin;

    // pin debounce for edge-sensitive sensing
    always_comb begin
        armed_nxt = armed_r;
        dcnt_nxt  = dcnt_r;
        pend_nxt  = pend_r;
        if (pin) begin
            armed_nxt = 1'b0;
            dcnt_nxt  = '0;
            pend_nxt  = 1'b0;
        end else if (pin_fall) begin
            armed_nxt = 1'b1;
            dcnt_nxt  = '0;
        end else if (armed_r) begin
            if (dcnt_r + 16'h0001 >= dbnc_r) begin
                armed_nxt = 1'b0;
                pend_nxt  = 1'b1;
            end else begin
                dcnt_nxt = dcnt_r + 16'h0001;
            end
        end
        if (st_r == puq_pkg::S_LPOFF && evt && qual) begin
            pend_nxt = 1'b0;
        end
    end

    // startup sequencing
    always_comb begin
        st_nxt    = st_r;
        cnt_nxt   = cnt_r;
        fpin_nxt  = fpin_r;
        fovs_nxt  = fovs_r;
        fdone_nxt = fdone_r;
        slot_nxt  = 1'b0;
        if (!uv_ok) begin
            st_nxt    = puq_pkg::S_NOPWR;
            fdone_nxt = 1'b0;
        end else begin
            case (st_r)
                puq_pkg::S_NOPWR: begin
                    st_nxt  = puq_pkg::S_FUSE;
                    cnt_nxt = '0;
                end
                puq_pkg::S_FUSE: begin
                    cnt_nxt = cnt_r + CW'(1);
                    if (cnt_r == CW'(FUSE_CYC - 1)) begin
                        st_nxt    = puq_pkg::S_LPOFF;
                        fdone_nxt = 1'b1;
                        fpin_nxt  = s2_r[puq_pkg::SY_FPIN];
                        fovs_nxt  = s2_r[puq_pkg::SY_FOVS];
                    end
                end
                puq_pkg::S_LPOFF: begin
                    // pin low at supply arrival parks here
                    if (evt && qual) begin
                        st_nxt  = puq_pkg::S_BIAS;
                        cnt_nxt = '0;
                    end
                end
                puq_pkg::S_BIAS: begin
                    // one bias path for both pin modes
                    cnt_nxt = cnt_r + CW'(1);
                    if (!qual) begin
                        st_nxt = puq_pkg::S_LPOFF;
                    end else if (cnt_r == CW'(BIAS_CYC - 1)) begin
                        st_nxt   = puq_pkg::S_RUN;
                        slot_nxt = 1'b1;
                    end
                end
                puq_pkg::S_RUN: st_nxt = puq_pkg::S_RUN;
                default:        st_nxt = puq_pkg::S_NOPWR;
            endcase
        end
    end

    // apb slave, one wait state so read data comes from a flop
    assign access  = psel & penable;
    assign wr_fire = access & pready_r & pwrite;

    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr)
            puq_pkg::ADDR_CTRL: begin
                rd_val[puq_pkg::CTRL_LPOFF_BIT] = lpoff_r;
                rd_val[puq_pkg::CTRL_OVSEL_LSB +: 2] = ovsel_r;
                rd_val[puq_pkg::CTRL_OVEN_BIT] = oven_r;
            end
            puq_pkg::ADDR_DBNC: rd_val[15:0] = dbnc_r;
            puq_pkg::ADDR_STATUS: begin
                rd_val[puq_pkg::ST_STATE_LSB +: 3] = st_r;
                rd_val[puq_pkg::ST_FDONE_BIT] = fdone_r;
                rd_val[puq_pkg::ST_FPIN_BIT]  = fpin_r;
                rd_val[puq_pkg::ST_FOVS_BIT]  = fovs_r;
                rd_val[puq_pkg::ST_QUAL_BIT]  = qual;
                rd_val[puq_pkg::ST_OVF_BIT]   = ovc.ov_flag;
                rd_val[puq_pkg::ST_PEND_BIT]  = pend_r;
            end
            default: rd_hit = 1'b0;
        endcase
        pready_nxt  = access & ~pready_r;
        prdata_nxt  = prdata_r;
        pslverr_nxt = 1'b0;
        if (access && !pready_r) begin
            prdata_nxt  = pwrite ? 32'h0000_0000 : rd_val;
            pslverr_nxt = ~rd_hit |
                          (pwrite & (paddr == puq_pkg::ADDR_STATUS));
        end
        lpoff_nxt = lpoff_r;
        ovsel_nxt = ovsel_r;
        oven_nxt  = oven_r;
        dbnc_nxt  = dbnc_r;
        if (wr_fire && paddr == puq_pkg::ADDR_CTRL) begin
            if (st_r == puq_pkg::S_RUN) begin
                lpoff_nxt = pwdata[puq_pkg::CTRL_LPOFF_BIT];
            end
            ovsel_nxt = pwdata[puq_pkg::CTRL_OVSEL_LSB +: 2];
            oven_nxt  = pwdata[puq_pkg::CTRL_OVEN_BIT];
        end
        if (wr_fire && paddr == puq_pkg::ADDR_DBNC) begin
            dbnc_nxt = pwdata[15:0];
        end
        // supply arrival outranks a coincident software write
        if (uv_rise) begin
            lpoff_nxt = puq_pkg::CTRL_LPOFF_RST;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r      <= puq_pkg::S_NOPWR;
            cnt_r     <= '0;
            dcnt_r    <= '0;
            armed_r   <= 1'b0;
            pend_r    <= 1'b0;
            pin_d_r   <= 1'b0;
            uv_d_r    <= 1'b0;
            fpin_r    <= 1'b0;
            fovs_r    <= 1'b0;
            fdone_r   <= 1'b0;
            slot_r    <= 1'b0;
            lpoff_r   <= puq_pkg::CTRL_LPOFF_RST;
            ovsel_r   <= puq_pkg::CTRL_OVSEL_RST;
            oven_r    <= puq_pkg::CTRL_OVEN_RST;
            dbnc_r    <= puq_pkg::DBNC_RST;
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            cnt_r     <= cnt_nxt;
            dcnt_r    <= dcnt_nxt;
            armed_r   <= armed_nxt;
            pend_r    <= pend_nxt;
            pin_d_r   <= pin;
            uv_d_r    <= uv_ok;
            fpin_r    <= fpin_nxt;
            fovs_r    <= fovs_nxt;
            fdone_r   <= fdone_nxt;
            slot_r    <= slot_nxt;
            lpoff_r   <= lpoff_nxt;
            ovsel_r   <= ovsel_nxt;
            oven_r    <= oven_nxt;
            dbnc_r    <= dbnc_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata              = prdata_r;
    assign pready              = pready_r;
    assign pslverr             = pslverr_r & pready_r;
    assign fuse_load_done      = fdone_r;
    assign low_power_off_state = (st_r == puq_pkg::S_LPOFF);
    assign run_mode            = (st_r == puq_pkg::S_RUN);
    assign first_slot_start    = slot_r;
endmodule : puq_qualifier

// ---- testbench/puq_qualifier_asserts.sv ----
// port assertions for the power-up event qualifier
// assumes a bind onto puq_qualifier with its cut-down parameters
`timescale 1ns/100ps
module puq_qualifier_asserts #(
    parameter int FUSE_CYC = 20,
    parameter int BIAS_CYC = 5
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic vin_above_uv,
    input wire logic trim_fault,
    input wire logic fuse_fault,
    input wire logic self_test_fault,
    input wire logic thermal_shutdown,
    input wire logic fuse_load_done,
    input wire logic low_power_off_state,
    input wire logic run_mode,
    input wire logic first_slot_start
);
    // slack covers the two synchroniser flops and the state flop
    localparam int FL = FUSE_CYC + 6;
    localparam int BL = BIAS_CYC + 4;
    logic flt;
    assign flt = trim_fault | fuse_fault | self_test_fault | thermal_shutdown;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_slot_run: assert property (first_slot_start |-> ##[0:1] run_mode)
        else $error("slot start without run");
    a_run_from_slot: assert property ($rose(run_mode) |->
        (first_slot_start || $past(first_slot_start))) else $error("run no slot");
    a_fuse_time: assert property ($rose(vin_above_uv) |->
        ##[1:FL] (fuse_load_done || !vin_above_uv)) else $error("fuse load late");
    a_off_fused: assert property ((low_power_off_state || run_mode)
        |-> fuse_load_done) else $error("state ahead of fuse load");
    a_no_supply: assert property (!vin_above_uv [*4] |-> !fuse_load_done
        && !run_mode && !low_power_off_state) else $error("alive without supply");
    a_fault_stop: assert property (flt [*4] |-> !first_slot_start)
        else $error("slot start during fault");
    a_lp_exit: assert property ($fell(low_power_off_state) |-> ##[1:BL]
        (first_slot_start || low_power_off_state || !fuse_load_done))
        else $error("bias phase overran");
    a_apb_wait: assert property (psel && penable && !$past(penable)
        |-> !pready ##1 pready) else $error("apb wait state wrong");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule : puq_qualifier_asserts

// ---- testbench/puq_ctrl_model.sv ----
// system controller model driving the power-on pin
// assumes want_on changes just after a rising edge
`timescale 1ns/100ps
module puq_ctrl_model (
    input  wire logic ref_clk,
    input  wire logic edge_mode,
    input  wire logic want_on,
    output logic      power_on_pin
);
    logic hold_r;
    always_ff @(posedge ref_clk) begin
        hold_r <= want_on;
    end
    // edge mode idles high; a request is a fall held low
    assign power_on_pin = edge_mode ? !hold_r : hold_r;
endmodule : puq_ctrl_model

// ---- testbench/tb.sv ----
// self-checking bench for the power-up event qualifier
// assumes cut-down fuse and bias counts for a short run
`timescale 1ns/100ps
module tb;
    localparam int FC = 20;
    localparam int BC = 5;
    logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, e;
    logic        pin, uv, ov, fps, fos, want, fld, lpo, run, slot, ev;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv, seed;
    logic [3:0]  flt, ctrl_m;
    logic [15:0] dbnc_m;
    logic [2:0]  st_m;
    int          mismatches, n_checks, cyc, t0;
    puq_qualifier #(.FUSE_CYC(FC), .BIAS_CYC(BC), .OV_1K(30))
        puq_qualifier_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .power_on_pin(pin), .vin_above_uv(uv), .vin_above_ovlo(ov),
        .trim_fault(flt[0]), .fuse_fault(flt[1]), .self_test_fault(flt[2]),
        .thermal_shutdown(flt[3]), .fused_pin_sense_select(fps),
        .fused_overvoltage_shutdown_select(fos), .fuse_load_done(fld),
        .low_power_off_state(lpo), .run_mode(run), .first_slot_start(slot));
    puq_ctrl_model puq_ctrl_model_inst (.ref_clk(ref_clk), .edge_mode(fps),
        .want_on(want), .power_on_pin(pin));
    initial begin
        ref_clk = 1'h0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            end_sim();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            mismatches++;
            $display("unexpected at %0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    // the master never assumes the wait count, only the bench timeout
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        // sample at the rising edge, before the slave's flops move
        @(posedge ref_clk);
        while (pready !== 1'h1) @(posedge ref_clk);
        rv = prdata;
        e  = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic rchk(input logic [11:0] a, input logic x);
        logic [31:0] m, v;
        m = 32'hFFFFFFFF;
        v = 32'h0;
        if (a == puq_pkg::ADDR_CTRL) v = ctrl_m;
        if (a == puq_pkg::ADDR_DBNC) v = dbnc_m;
        if (a == puq_pkg::ADDR_STATUS) begin
            m = 32'h3F;
            v = {26'h0, fos, fps, st_m > 3'h1, st_m};
        end
        apb(1'h0, a, 32'h0);
        chk(rv & m, v);
        chk(e, x);
    endtask : rchk
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic x);
        apb(1'h1, a, d);
        chk(e, x);
        if (a == puq_pkg::ADDR_DBNC) dbnc_m = d[15:0];
        if (a == puq_pkg::ADDR_CTRL)
            ctrl_m = {d[3:1], st_m == 3'h4 ? d[0] : ctrl_m[0]};
    endtask : wr
    task automatic pwr(input logic on);
        @(posedge ref_clk);
        uv   <= 1'h0;
        want <= on;
        repeat (6) @(posedge ref_clk);
        uv <= 1'h1;
        t0 = cyc;
        ctrl_m[0] = 1'h0;
        st_m = 3'h2;
        @(negedge ref_clk);
        while (fld !== 1'h1 && cyc - t0 < 100) @(negedge ref_clk);
        chk(cyc - t0 <= FC + 5, 1'h1);
        chk(lpo | run, 1'h1);
    endtask : pwr
    task automatic pin_to(input logic v);
        @(posedge ref_clk);
        want <= v;
        t0 = cyc;
    endtask : pin_to
    task automatic wslot(input int lim);
        while (slot !== 1'h1 && cyc - t0 < lim) @(negedge ref_clk);
        chk(slot, 1'h1);
        st_m = 3'h4;
        @(negedge ref_clk);
        chk(run, 1'h1);
    endtask : wslot
    task automatic nslot(input int k);
        ev = 1'h0;
        repeat (k) begin
            @(negedge ref_clk);
            ev = ev | slot | run;
        end
        chk(ev, 1'h0);
    endtask : nslot
    initial begin
        {psel, penable, pwrite, uv, ov, fps, fos, want} = 8'h0;
        {paddr, pwdata, flt, st_m, cyc, mismatches, n_checks} = '0;
        seed = 32'hB9DCE493;
        ctrl_m = 4'h8;
        dbnc_m = 16'h0100;
        rst = 1'h1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'h0;
        rchk(puq_pkg::ADDR_CTRL, 1'h0);
        rchk(puq_pkg::ADDR_DBNC, 1'h0);
        rchk(12'h00C, 1'h1);
        wr(puq_pkg::ADDR_STATUS, 32'h1, 1'h1);
        rchk(puq_pkg::ADDR_STATUS, 1'h0);
        for (int i = 0; i < 4; i++) begin
            wr(puq_pkg::ADDR_CTRL, xs() & 32'hFFFFFFF9 | i << 1, 1'h0);
            rchk(puq_pkg::ADDR_CTRL, 1'h0);
        end
        wr(puq_pkg::ADDR_DBNC, xs(), 1'h0);
        rchk(puq_pkg::ADDR_DBNC, 1'h0);
        $display("register test done");
        pwr(1'h0);
        rchk(puq_pkg::ADDR_STATUS, 1'h0);
        wr(puq_pkg::ADDR_CTRL, 32'h9, 1'h0);
        rchk(puq_pkg::ADDR_CTRL, 1'h0);
        nslot(20);
        pin_to(1'h1);
        wslot(BC + 10);
        wr(puq_pkg::ADDR_CTRL, 32'h9, 1'h0);
        rchk(puq_pkg::ADDR_CTRL, 1'h0);
        pwr(1'h1);
        wslot(FC + BC + 12);
        rchk(puq_pkg::ADDR_CTRL, 1'h0);
        $display("level mode test done");
        // one fault at a time; the last two pass overvoltage by select
        // and by lockout disabled
        for (int k = 0; k < 7; k++) begin
            if (k == 6) wr(puq_pkg::ADDR_CTRL, 32'h0, 1'h0);
            @(posedge ref_clk);
            flt <= 4'h1 << k;
            ov  <= k > 3;
            fos <= k != 5;
            // 10us filter: still clear near 240 cycles, set by 300
            repeat (240) @(posedge ref_clk);
            apb(1'h0, puq_pkg::ADDR_STATUS, 32'h0);
            if (k == 4) chk(rv[7], 1'h0);
            repeat (60) @(posedge ref_clk);
            apb(1'h0, puq_pkg::ADDR_STATUS, 32'h0);
            if (k == 4) chk(rv[7], 1'h1);
            pwr(1'h1);
            if (k < 5) begin
                nslot(300);
                pin_to(1'h1);
                flt <= 4'h0;
                ov  <= 1'h0;
            end
            wslot(300);
        end
        $display("qualification test done");
        @(posedge ref_clk);
        ov  <= 1'h0;
        fps <= 1'h1;
        pwr(1'h0);
        rchk(puq_pkg::ADDR_STATUS, 1'h0);
        wr(puq_pkg::ADDR_DBNC, 32'h8, 1'h0);
        pin_to(1'h1);
        repeat (3) @(posedge ref_clk);
        want <= 1'h0;
        nslot(30);
        pin_to(1'h1);
        wslot(BC + 20);
        $display("edge mode test done");
        end_sim();
    end
endmodule : tb
bind puq_qualifier puq_qualifier_asserts #(.FUSE_CYC(FUSE_CYC),
    .BIAS_CYC(BIAS_CYC)) puq_qualifier_asserts_inst (.ref_clk(ref_clk),
    .rst(rst), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .vin_above_uv(vin_above_uv), .trim_fault(trim_fault),
    .fuse_fault(fuse_fault), .self_test_fault(self_test_fault),
    .thermal_shutdown(thermal_shutdown), .fuse_load_done(fuse_load_done),
    .low_power_off_state(low_power_off_state), .run_mode(run_mode),
    .first_slot_start(first_slot_start));
